// ### rtl/idpc_pkg.sv
`default_nettype none
package idpc_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] REGULATOR_SLEEP_CONTROL_OFF = 8'h00;
    localparam logic [7:0] CPU_THROTTLE_IDLE_CONTROL_OFF = 8'h04;
    localparam int ADDR_W = 8;

    // Regulator control register fields
    localparam int REG_PM_BIT = 1;
    localparam int REG_RSVD_BIT = 0;
    localparam logic REG_PM_RESET = 1'b0;

    // Throttle and idle control register fields
    localparam int IDLE_SEL_BIT = 7;
    localparam int THROTTLE_BIT = 6;
    localparam int WAKE_FS_BIT = 5;
    localparam int SLOW_RET_BIT = 4;
    localparam int RATIO_MSB = 2;
    localparam int RATIO_LSB = 0;
    localparam int RATIO_W = 3;
    localparam logic IDLE_SEL_RESET = 1'b0;
    localparam logic THROTTLE_RESET = 1'b0;
    localparam logic WAKE_FS_RESET = 1'b0;
    localparam logic SLOW_RET_RESET = 1'b0;
    localparam logic [2:0] RATIO_RESET = 3'h0;

    // Clocks per peripheral instruction cycle
    localparam int INSTR_DIV_CYCLES = 4;
    localparam int DIV_W = 2;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INSTR_DIV_CYCLES - 1);

    // Throttle counter width, enough for 1:256
    localparam int THR_CNT_W = 8;
    localparam logic [THR_CNT_W-1:0] THR_CNT_RESET = 8'h00;

    // Power state
    typedef enum logic [1:0] {
        IDPC_RUN = 2'b00,
        IDPC_IDLE = 2'b01,
        IDPC_SLEEP = 2'b10
    } idpc_state_t;
endpackage
`default_nettype wire

// ### rtl/idpc_throttle.sv
`timescale 1ns/1ns
`default_nettype none
module idpc_throttle (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Rate control
    input wire logic periph_en,
    input wire logic throttle_on,
    input wire logic [idpc_pkg::RATIO_W-1:0] ratio,
    // CPU cycle enable
    output logic cpu_en
);
    typedef struct packed {
        logic [idpc_pkg::THR_CNT_W-1:0] cnt;
    } idpc_thr_t;

    idpc_thr_t st_reg;
    idpc_thr_t st_next;

    // Last count of a 1:N ratio, N = 2 << code
    function automatic logic [idpc_pkg::THR_CNT_W-1:0] ratio_last(input logic [idpc_pkg::RATIO_W-1:0] code);
        logic [idpc_pkg::THR_CNT_W:0] n;
        n = 9'h002 << code;
        return idpc_pkg::THR_CNT_W'(n - 9'h001);
    endfunction

    logic at_last;
    assign at_last = (st_reg.cnt >= ratio_last(ratio));

    // One CPU cycle per N peripheral cycles when throttled
    assign cpu_en = periph_en & (~throttle_on | at_last);

    // Peripheral cycle counter
    always_comb begin
        st_next = st_reg;
        if (!throttle_on) begin
            st_next.cnt = idpc_pkg::THR_CNT_RESET;
        end else if (periph_en) begin
            st_next.cnt = at_last ? idpc_pkg::THR_CNT_RESET : st_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{cnt: idpc_pkg::THR_CNT_RESET};
        end else begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    full_rate_a: assert property (!throttle_on && periph_en |-> cpu_en)
        else $error("full speed cycle skipped");
    ratio_code0_a: assert property (
        throttle_on && ratio == 3'h0 && cpu_en ##4 (throttle_on && ratio == 3'h0 && periph_en) |-> !cpu_en)
        else $error("ratio 1:2 gave back to back cpu cycles");
    cnt_bound_a: assert property (throttle_on && periph_en |=> st_reg.cnt <= ratio_last($past(ratio)))
        else $error("throttle count past ratio");
endmodule // idpc_throttle
`default_nettype wire

// ### rtl/idpc_power_ctrl.sv
// What this block does
// - Enabled interrupt ends Idle; idle select kept
// - Power-down with idle select re-enters Idle
// - Idle interrupt wake clears throttle if enabled
// - Watchdog timeout in Idle wakes, no reset
// - Watchdog wake leaves throttle bit untouched
// - Regulator mode bit picks low-power Sleep
// - Regulator bits 7-2 read 0, bit 0 reads 1
// - Idle select: Idle or full Sleep
// - Throttle bit slows CPU by ratio
// - Wake-at-full-speed clears throttle on ISR entry
// - Slow-on-return sets throttle on interrupt return
// - Ratio code sets 1:2 to 1:256
// - Debug entry forces full speed, bit kept
// - Idle select survives resets other than power-on or brown-out
// - Idle halts CPU and program memory only
// - Only enabled interrupt sources or a watchdog timeout wake
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module idpc_power_ctrl #(
    parameter int NUM_INT = 8
) (
    // Clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic por_bor_resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [idpc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CPU core, interrupt logic and watchdog events
    input wire logic sleep_instr,
    input wire logic [NUM_INT-1:0] int_flags,
    input wire logic [NUM_INT-1:0] int_enables,
    input wire logic isr_entry,
    input wire logic return_from_interrupt_instr,
    input wire logic watchdog_timeout,
    input wire logic in_circuit_debug_entry,
    // Clock gating and power outputs
    output logic periph_cycle_en,
    output logic cpu_cycle_en,
    output logic pfm_en,
    output logic idle_active,
    output logic sleep_active,
    output logic regulator_low_power,
    output logic wake_pulse,
    output logic watchdog_reset_req
);
    typedef struct packed {
        idpc_pkg::idpc_state_t state;
        logic reg_pm;
        logic throttle;
        logic wake_fs;
        logic slow_ret;
        logic [idpc_pkg::RATIO_W-1:0] ratio;
        logic [31:0] rdata;
        logic wake;
        logic wdt_rst;
        logic [idpc_pkg::DIV_W-1:0] div;
        logic periph_en;
    } idpc_core_t;

    idpc_core_t st_reg;
    idpc_core_t st_next;
    logic idle_sel_reg;
    logic idle_sel_next;

    // Register decode shared by read and write
    function automatic logic [1:0] reg_hit(input logic [idpc_pkg::ADDR_W-1:0] a);
        return {a == idpc_pkg::CPU_THROTTLE_IDLE_CONTROL_OFF, a == idpc_pkg::REGULATOR_SLEEP_CONTROL_OFF};
    endfunction

    logic [1:0] hit;
    logic setup_ph;
    logic wr_acc;
    logic wr_reg;
    logic wr_thr;
    logic wake_int;
    logic throttle_eff;
    logic cpu_en_raw;
    logic in_run;

    assign hit = reg_hit(paddr);
    assign setup_ph = psel & ~penable;
    assign wr_acc = psel & penable & pwrite & pstrb[0];
    assign wr_reg = wr_acc & hit[0];
    assign wr_thr = wr_acc & hit[1];
    assign wake_int = |(int_flags & int_enables);
    assign in_run = (st_reg.state == idpc_pkg::IDPC_RUN);
    assign throttle_eff = st_reg.throttle & ~in_circuit_debug_entry;

    // Zero wait state slave, error on unmapped address
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(|hit);
    assign prdata = st_reg.rdata;

    idpc_throttle u_throttle (
        .pclk(pclk),
        .presetn(presetn),
        .periph_en(st_reg.periph_en),
        .throttle_on(throttle_eff),
        .ratio(st_reg.ratio),
        .cpu_en(cpu_en_raw)
    );

    // Gating outputs
    assign periph_cycle_en = st_reg.periph_en;
    assign cpu_cycle_en = cpu_en_raw & in_run;
    assign pfm_en = in_run;
    assign idle_active = (st_reg.state == idpc_pkg::IDPC_IDLE);
    assign sleep_active = (st_reg.state == idpc_pkg::IDPC_SLEEP);
    assign regulator_low_power = sleep_active & st_reg.reg_pm;
    assign wake_pulse = st_reg.wake;
    assign watchdog_reset_req = st_reg.wdt_rst;

    // Idle select, cleared only by power-on or brown-out reset
    always_comb begin
        idle_sel_next = idle_sel_reg;
        if (wr_thr) begin
            idle_sel_next = pwdata[idpc_pkg::IDLE_SEL_BIT];
        end
    end

    always_ff @(posedge pclk or negedge por_bor_resetn) begin
        if (!por_bor_resetn) begin
            idle_sel_reg <= idpc_pkg::IDLE_SEL_RESET;
        end else begin
            idle_sel_reg <= idle_sel_next;
        end
    end

    // Core next state: divider, power state, control bits, read data
    always_comb begin
        st_next = st_reg;
        st_next.wake = 1'b0;
        st_next.wdt_rst = 1'b0;
        st_next.periph_en = (st_reg.div == idpc_pkg::DIV_LAST);
        st_next.div = st_next.periph_en ? '0 : st_reg.div + 2'h1;
        if (setup_ph) begin
            st_next.rdata = 32'h0000_0000;
            if (hit[0]) begin
                st_next.rdata[idpc_pkg::REG_PM_BIT] = st_reg.reg_pm;
                st_next.rdata[idpc_pkg::REG_RSVD_BIT] = 1'b1;
            end else if (hit[1]) begin
                st_next.rdata[idpc_pkg::IDLE_SEL_BIT] = idle_sel_reg;
                st_next.rdata[idpc_pkg::THROTTLE_BIT] = st_reg.throttle;
                st_next.rdata[idpc_pkg::WAKE_FS_BIT] = st_reg.wake_fs;
                st_next.rdata[idpc_pkg::SLOW_RET_BIT] = st_reg.slow_ret;
                st_next.rdata[idpc_pkg::RATIO_MSB:idpc_pkg::RATIO_LSB] = st_reg.ratio;
            end
        end
        // Software writes first, hardware events override them
        if (wr_reg) begin
            st_next.reg_pm = pwdata[idpc_pkg::REG_PM_BIT];
        end
        if (wr_thr) begin
            st_next.throttle = pwdata[idpc_pkg::THROTTLE_BIT];
            st_next.wake_fs = pwdata[idpc_pkg::WAKE_FS_BIT];
            st_next.slow_ret = pwdata[idpc_pkg::SLOW_RET_BIT];
            st_next.ratio = pwdata[idpc_pkg::RATIO_MSB:idpc_pkg::RATIO_LSB];
        end
        if (isr_entry && st_reg.wake_fs) begin
            st_next.throttle = 1'b0;
        end
        case (st_reg.state)
            idpc_pkg::IDPC_RUN: begin
                if (watchdog_timeout) begin
                    st_next.wdt_rst = 1'b1;
                end else if (sleep_instr && !wake_int) begin
                    st_next.state = idle_sel_reg ? idpc_pkg::IDPC_IDLE : idpc_pkg::IDPC_SLEEP;
                end
            end
            idpc_pkg::IDPC_IDLE: begin
                if (wake_int) begin
                    st_next.state = idpc_pkg::IDPC_RUN;
                    st_next.wake = 1'b1;
                    if (st_reg.wake_fs && st_reg.throttle) begin
                        st_next.throttle = 1'b0;
                    end
                end else if (watchdog_timeout) begin
                    st_next.state = idpc_pkg::IDPC_RUN;
                    st_next.wake = 1'b1;
                end
            end
            idpc_pkg::IDPC_SLEEP: begin
                if (wake_int || watchdog_timeout) begin
                    st_next.state = idpc_pkg::IDPC_RUN;
                    st_next.wake = 1'b1;
                end
            end
            default: begin
                st_next.state = idpc_pkg::IDPC_RUN;
            end
        endcase
        // Set wins over any clear in the same cycle
        if (return_from_interrupt_instr && st_reg.slow_ret) begin
            st_next.throttle = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{state: idpc_pkg::IDPC_RUN, reg_pm: idpc_pkg::REG_PM_RESET,
                        throttle: idpc_pkg::THROTTLE_RESET, wake_fs: idpc_pkg::WAKE_FS_RESET,
                        slow_ret: idpc_pkg::SLOW_RET_RESET, ratio: idpc_pkg::RATIO_RESET,
                        rdata: 32'h0000_0000, wake: 1'b0, wdt_rst: 1'b0, div: '0,
                        periph_en: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence idle_int_s;
        idle_active && wake_int;
    endsequence

    sequence back_in_run_s;
        in_run && wake_pulse;
    endsequence

    idle_wake_a: assert property (idle_int_s |=> back_in_run_s)
        else $error("interrupt did not end idle");
    idle_keep_a: assert property ((idle_int_s and !wr_thr) |=> idle_sel_reg == $past(idle_sel_reg))
        else $error("idle select changed on wake");
    idle_reenter_a: assert property (
        in_run && sleep_instr && !wake_int && !watchdog_timeout && idle_sel_reg |=> idle_active)
        else $error("power-down did not enter idle");
    sleep_enter_a: assert property (
        in_run && sleep_instr && !wake_int && !watchdog_timeout && !idle_sel_reg |=> sleep_active)
        else $error("power-down did not enter sleep");
    roi_wake_a: assert property (
        (idle_int_s and (st_reg.wake_fs && st_reg.throttle && !(return_from_interrupt_instr && st_reg.slow_ret)))
        |=> !st_reg.throttle)
        else $error("idle wake kept throttle");
    wdt_block_a: assert property (
        !in_run && watchdog_timeout |=> !watchdog_reset_req ##1 ($past(watchdog_timeout) || !watchdog_reset_req))
        else $error("watchdog reset out of power-down");
    wdt_run_a: assert property (in_run && watchdog_timeout |=> watchdog_reset_req)
        else $error("watchdog reset missing");
    wdt_wake_a: assert property (
        idle_active && watchdog_timeout && !wake_int && !wr_thr && !isr_entry && !return_from_interrupt_instr
        |=> in_run && st_reg.throttle == $past(st_reg.throttle))
        else $error("watchdog wake touched throttle");
    reg_lp_a: assert property (regulator_low_power == (sleep_active && st_reg.reg_pm))
        else $error("regulator mode wrong");
    reg_read_a: assert property (setup_ph && hit[0] |=> prdata[31:2] == 30'h0 && prdata[0])
        else $error("regulator register read wrong");
    isr_clear_a: assert property (
        isr_entry && st_reg.wake_fs && !(return_from_interrupt_instr && st_reg.slow_ret) |=> !st_reg.throttle)
        else $error("isr entry kept throttle");
    return_from_interrupt_instr_set_a: assert property (return_from_interrupt_instr && st_reg.slow_ret |=> st_reg.throttle)
        else $error("return did not set throttle");
    debug_full_a: assert property (in_circuit_debug_entry |-> cpu_cycle_en == (periph_cycle_en && in_run))
        else $error("debug not at full speed");
    idle_halt_a: assert property (!in_run |-> !cpu_cycle_en && !pfm_en)
        else $error("cpu ran in power-down");
    periph_run_a: assert property (idle_active |-> ##[0:3] periph_cycle_en)
        else $error("peripheral cycles stopped in idle");
    mask_a: assert property (idle_active && !(|(int_flags & int_enables)) && !watchdog_timeout |=> idle_active)
        else $error("disabled source woke device");
endmodule // idpc_power_ctrl
`default_nettype wire

// ### rtl/idpc_placeholder_none.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ### tb/idpc_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module idpc_cpu_model #(
    parameter int NUM_INT = 8
) (
    // Clock
    input wire logic pclk,
    // Core events
    output logic sleep_instr,
    output logic isr_entry,
    output logic return_from_interrupt_instr,
    output logic watchdog_timeout,
    output logic in_circuit_debug_entry,
    // Interrupt logic
    output logic [NUM_INT-1:0] int_flags,
    output logic [NUM_INT-1:0] int_enables
);
    // All events quiet at start
    initial begin
        sleep_instr = 1'h0;
        isr_entry = 1'h0;
        return_from_interrupt_instr = 1'h0;
        watchdog_timeout = 1'h0;
        in_circuit_debug_entry = 1'h0;
        int_flags = '0;
        int_enables = '0;
    end

    // One-cycle event: 0 power-down, 1 ISR entry, 2 return, 3 timeout
    task automatic pulse(input int k);
        @(posedge pclk);
        sleep_instr <= (k == 0);
        isr_entry <= (k == 1);
        return_from_interrupt_instr <= (k == 2);
        watchdog_timeout <= (k == 3);
        @(posedge pclk);
        sleep_instr <= 1'h0;
        isr_entry <= 1'h0;
        return_from_interrupt_instr <= 1'h0;
        watchdog_timeout <= 1'h0;
    endtask

    // Flag held for a prompt or slow service, then cleared by software
    task automatic irq(input int src, input logic en, input int hold);
        @(posedge pclk);
        int_enables <= {{(NUM_INT-1){1'h0}}, en} << src;
        int_flags <= {{(NUM_INT-1){1'h0}}, 1'h1} << src;
        repeat (hold) @(posedge pclk);
        int_flags <= '0;
    endtask

    // Debug session level
    task automatic debug(input logic lvl);
        @(posedge pclk);
        in_circuit_debug_entry <= lvl;
    endtask
endmodule // idpc_cpu_model
`default_nettype wire

// ### tb/idle_doze_power_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin bad_count++; \
    $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module idle_doze_power_control_bench;
    localparam logic [7:0] A0 = idpc_pkg::REGULATOR_SLEEP_CONTROL_OFF;
    localparam logic [7:0] A1 = idpc_pkg::CPU_THROTTLE_IDLE_CONTROL_OFF;
    logic pclk = 1'h0, presetn, por_bor_resetn;
    logic psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, seed = 32'h48;
    logic [3:0] pstrb;
    logic pready, pslverr, sleep_instr, isr_entry, ret_instr, wdt_to, dbg;
    logic [7:0] int_flags, int_enables;
    logic periph_cycle_en, cpu_cycle_en, pfm_en, idle_active, sleep_active;
    logic regulator_low_power, wake_pulse, watchdog_reset_req;
    logic [7:0] tbl_w [4] = '{8'h70, 8'h30, 8'h40, 8'h00};
    logic [7:0] tbl_x [4] = '{8'h30, 8'h70, 8'h40, 8'h00};
    int bad_count = 0, checks = 0;

    // Clock at 250 MHz
    always #2 pclk = ~pclk;

    idpc_power_ctrl #(.NUM_INT(8)) u_dut (.pclk(pclk), .presetn(presetn), .por_bor_resetn(por_bor_resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_instr(sleep_instr),
        .int_flags(int_flags), .int_enables(int_enables), .isr_entry(isr_entry),
        .return_from_interrupt_instr(ret_instr), .watchdog_timeout(wdt_to),
        .in_circuit_debug_entry(dbg), .periph_cycle_en(periph_cycle_en), .cpu_cycle_en(cpu_cycle_en),
        .pfm_en(pfm_en), .idle_active(idle_active), .sleep_active(sleep_active),
        .regulator_low_power(regulator_low_power), .wake_pulse(wake_pulse),
        .watchdog_reset_req(watchdog_reset_req));

    idpc_cpu_model #(.NUM_INT(8)) u_cpu (.pclk(pclk), .sleep_instr(sleep_instr), .isr_entry(isr_entry),
        .return_from_interrupt_instr(ret_instr), .watchdog_timeout(wdt_to),
        .in_circuit_debug_entry(dbg), .int_flags(int_flags), .int_enables(int_enables));

    // Fixed-seed xorshift
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // One APB transfer, held until pready at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // CPU cycles seen over a number of peripheral cycles
    task automatic count(input int p, output int n);
        int c;
        c = 0;
        n = 0;
        while (c < p) begin
            @(negedge pclk);
            if (periph_cycle_en === 1'h1) c++;
            if (cpu_cycle_en === 1'h1) n++;
        end
    endtask

    // Collect wake and reset-request pulses
    task automatic watch(input int c, output logic wk, output logic rr);
        wk = 1'h0;
        rr = 1'h0;
        repeat (c) begin
            @(negedge pclk);
            wk |= wake_pulse;
            rr |= watchdog_reset_req;
        end
    endtask

    // Mid-run reset, with or without power-on
    task automatic rst(input logic por);
        @(posedge pclk);
        presetn <= 1'h0;
        por_bor_resetn <= !por;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        por_bor_resetn <= 1'h1;
    endtask

    task automatic conclude();
        if (bad_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (40000) @(posedge pclk);
        bad_count++;
        conclude();
    end

    // Main sequence
    initial begin
        logic [31:0] q, r;
        logic e, wk, rr;
        int n, k;
        // Quiet bus, resets held
        presetn = 1'h0;
        por_bor_resetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        por_bor_resetn <= 1'h1;
        apb(0, A0, 0, q, e);
        `CHK("regulator reset", 32'h1, q)
        apb(0, A1, 0, q, e);
        `CHK("throttle reset", 32'h0, q)
        apb(0, 8'h08, 0, q, e);
        `CHK("unmapped error", 1'h1, e)
        `CHK("unmapped data", 32'h0, q)
        for (k = 0; k < 4; k++) begin
            r = xs();
            apb(1, A0, r | 32'h1, q, e);
            apb(0, A0, 0, q, e);
            `CHK("regulator bits", {30'h0, r[1], 1'h1}, q)
        end
        pstrb <= 4'hE;
        apb(1, A0, ~r, q, e);
        pstrb <= 4'hF;
        apb(0, A0, 0, q, e);
        `CHK("strobe off write", {30'h0, r[1], 1'h1}, q)
        for (k = 0; k < 8; k++) begin
            apb(1, A1, 0, q, e);
            count(8, n);
            `CHK("full rate", 8, n)
            apb(1, A1, 32'h40 | k, q, e);
            count(4 << k, n);
            `CHK("throttled rate", 2, n)
        end
        u_cpu.debug(1'h1);
        count(8, n);
        `CHK("debug full rate", 8, n)
        apb(0, A1, 0, q, e);
        `CHK("debug bit kept", 32'h47, q)
        u_cpu.debug(1'h0);
        for (k = 0; k < 4; k++) begin
            apb(1, A1, {24'h0, tbl_w[k]}, q, e);
            u_cpu.pulse(k % 2 + 1);
            apb(0, A1, 0, q, e);
            `CHK("hw throttle", {24'h0, tbl_x[k]}, q)
        end
        apb(1, A1, 32'hE3, q, e);
        u_cpu.pulse(0);
        @(negedge pclk);
        `CHK("idle entered", 1'h1, idle_active)
        `CHK("idle memory off", 1'h0, pfm_en)
        count(4, n);
        `CHK("idle cpu halted", 0, n)
        fork u_cpu.irq(3, 1'h0, 6); watch(10, wk, rr); join
        `CHK("masked source", 1'h0, wk)
        fork u_cpu.irq(5, 1'h1, 2); watch(10, wk, rr); join
        `CHK("enabled source", 1'h1, wk)
        apb(0, A1, 0, q, e);
        `CHK("idle wake bits", 32'hA3, q)
        apb(1, A1, 32'hE3, q, e);
        u_cpu.pulse(0);
        @(negedge pclk);
        `CHK("idle reentered", 1'h1, idle_active)
        fork u_cpu.pulse(3); watch(8, wk, rr); join
        `CHK("watchdog idle wake", 1'h1, wk)
        `CHK("watchdog no reset", 1'h0, rr)
        apb(0, A1, 0, q, e);
        `CHK("watchdog bits kept", 32'hE3, q)
        for (k = 0; k < 2; k++) begin
            apb(1, A0, 32'h1 | (k << 1), q, e);
            apb(1, A1, 0, q, e);
            u_cpu.pulse(0);
            @(negedge pclk);
            `CHK("full sleep", 1'h1, sleep_active)
            `CHK("regulator mode", k[0], regulator_low_power)
            fork u_cpu.irq(0, 1'h1, 2); watch(10, wk, rr); join
            `CHK("sleep wake", 1'h1, wk)
        end
        fork u_cpu.pulse(3); watch(8, wk, rr); join
        `CHK("watchdog run reset", 1'h1, rr)
        apb(1, A1, 32'hF5, q, e);
        rst(1'h0);
        apb(0, A1, 0, q, e);
        `CHK("warm reset bits", 32'h80, q)
        rst(1'h1);
        apb(0, A1, 0, q, e);
        `CHK("power-on bits", 32'h0, q)
        conclude();
    end
endmodule // idle_doze_power_control_bench
`default_nettype wire
